// ### cff_pkg.sv
package cff_pkg;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CFF_MODE_OFF,
    CFF_MODE_NORMAL,
    CFF_MODE_SILENT,
    CFF_MODE_STANDBY,
    CFF_MODE_GOTOSLEEP,
    CFF_MODE_SLEEP
  } cff_mode_t;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam int CFF_CLK_MHZ = 200;
  localparam int CFF_DOM_TIMEOUT_US = 1200;
  localparam int CFF_DOM_TIMEOUT_CYC = CFF_DOM_TIMEOUT_US * CFF_CLK_MHZ;
  localparam int CFF_BUS_DOM_US = 1400;
  localparam int CFF_BUS_DOM_CYC = CFF_BUS_DOM_US * CFF_CLK_MHZ;
  localparam int CFF_UV_FILTER_US = 100;
  localparam int CFF_UV_FILTER_CYC = CFF_UV_FILTER_US * CFF_CLK_MHZ;
  localparam int CFF_TMR_W = 20;
  localparam int CFF_EDGE_CNT = 4;
  localparam int CFF_EDGE_W = 3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic battery_uv;
    logic logic_uv;
    logic io_uv;
    logic overtemp;
    logic local_wake;
    logic remote_wake;
    logic bus_short;
  } cff_sense_t;

  typedef struct packed {
    logic cold_start_flag;
    logic wake_request_flag;
    logic wake_source_flag;
    logic wake_source_valid;
    logic bus_short_flag;
    logic tx_clamped_flag;
    logic tx_dominant_timeout_flag;
    logic tx_rx_short_flag;
    logic bus_stuck_dominant_flag;
    logic thermal_shutdown_flag;
    logic battery_undervoltage_flag;
    logic logic_supply_undervoltage_flag;
    logic io_supply_undervoltage_flag;
  } cff_flags_t;

endpackage : cff_pkg

// ### cff_timer.sv
`timescale 1ns/1ps
module cff_timer
  import cff_pkg::*;
#(
  parameter logic [CFF_TMR_W-1:0] LIMIT = 20'h003e8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Control
  input wire logic run,
  input wire logic clear,
  // Status
  output logic expired
);
  typedef struct packed {
    logic [CFF_TMR_W-1:0] count;
    logic expired;
  } cff_tmr_state_t;

  cff_tmr_state_t state_reg;
  cff_tmr_state_t state_next;

  always_comb begin
    state_next = state_reg;
    state_next.expired = 1'b0;
    if (clear || !run) begin
      state_next.count = '0;
    end else if (state_reg.count <= LIMIT) begin
      state_next.count = state_reg.count + 20'h00001;
      state_next.expired = state_reg.count == LIMIT;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign expired = state_reg.expired;
endmodule : cff_timer

// ### cff_fault_flags.sv
// Contract
// - Battery supply recovery sets cold start and wake request flags.
// - Cold start shown low after standby/sleep to silent; cleared entering normal.
// - Wake request set in standby, go-to-sleep, sleep on wakes or power-up.
// - Setting wake request restarts logic and I/O undervoltage filter timers.
// - Wake request clears entering normal or on logic/I/O undervoltage.
// - Go-to-sleep transitions are refused while wake request is set.
// - Wake source keeps the first recorded source while set.
// - Supply undervoltage flags never drive the fault indicator.
// - Logic and I/O undervoltage flags set only after the filter time.
// - Bus shorts (one bus_short sense input) are detected while transmitting dominant.
// - Short over four dominant-to-recessive edges flags bus fault in normal.
// - Four clean dominant-to-recessive edges in normal clear bus fault.
// - Transmit low at CAN active entry clamps and disables driver.
// - Clamp clears on power-up, recessive entry, or tx high rx low.
// - Transmit dominant beyond timeout disables driver and sets timeout flag.
// - Timeout flag clears on transmit rising edge or listed mode entry.
// - Transmit-receive short for timeout time sets flag, disables driver.
// - Short flag clears on edge with tx high rx low, or mode entry.
// - Bus dominant too long sets flag; clears on receive rise or mode entry.
// - Local faults other than thermal shown only on normal-to-silent; other transitions clear them.
// - Thermal shutdown disables driver, shows fault, clears on cool-down.
// - Entering normal shows wake source: low local, high remote.
`timescale 1ns/1ps
module cff_fault_flags
  import cff_pkg::*;
#(
  parameter int DOM_TIMEOUT_CYC = CFF_DOM_TIMEOUT_CYC,
  parameter int BUS_DOM_CYC = CFF_BUS_DOM_CYC,
  parameter int UV_FILTER_CYC = CFF_UV_FILTER_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Controller pins and mode
  input wire logic tx_data,
  input wire cff_mode_t mode_req,
  // Bus and analog sense
  input wire logic rx_data,
  input wire cff_sense_t sense,
  // Outputs
  output logic fault_indicator_low,
  output logic driver_enable,
  output cff_mode_t mode_active,
  output cff_flags_t flags
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] tx_sync;
    logic tx_s;
    logic [1:0] rx_sync;
    logic rx_s;
    cff_sense_t sense_s1;
    cff_sense_t sense_s;
    cff_mode_t mode_s1;
    cff_mode_t mode_s;
    cff_mode_t mode;
    cff_mode_t prev_mode;
    cff_flags_t f;
    logic [CFF_EDGE_W-1:0] short_edges;
    logic [CFF_EDGE_W-1:0] clean_edges;
    logic short_seen;
    logic fault_low;
    logic fault_pin;
    logic drv_en;
  } cff_state_t;

  cff_state_t state_reg;
  cff_state_t state_next;

  logic dto_exp;
  logic txrx_exp;
  logic busdom_exp;
  logic luv_exp;
  logic iouv_exp;
  logic uv_clear;
  logic tx_fall;
  logic tx_rise;
  logic rx_rise;
  logic can_active;
  logic txrx_shorted;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  assign can_active = (state_reg.mode == CFF_MODE_NORMAL) || (state_reg.mode == CFF_MODE_SILENT);
  assign txrx_shorted = can_active && !state_reg.tx_s && !state_reg.rx_s && !state_reg.drv_en;
  assign uv_clear = state_next.f.wake_request_flag && !state_reg.f.wake_request_flag;

  cff_timer #(.LIMIT(CFF_TMR_W'(DOM_TIMEOUT_CYC))) u_dto (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(can_active && state_reg.drv_en && !state_reg.tx_s),
    .clear(tx_fall),
    .expired(dto_exp)
  );
  cff_timer #(.LIMIT(CFF_TMR_W'(DOM_TIMEOUT_CYC))) u_txrx (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(txrx_shorted),
    .clear(1'b0),
    .expired(txrx_exp)
  );
  cff_timer #(.LIMIT(CFF_TMR_W'(BUS_DOM_CYC))) u_busdom (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(!state_reg.rx_s),
    .clear(1'b0),
    .expired(busdom_exp)
  );
  cff_timer #(.LIMIT(CFF_TMR_W'(UV_FILTER_CYC))) u_luv (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(state_reg.sense_s.logic_uv),
    .clear(uv_clear),
    .expired(luv_exp)
  );
  cff_timer #(.LIMIT(CFF_TMR_W'(UV_FILTER_CYC))) u_iouv (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(state_reg.sense_s.io_uv),
    .clear(uv_clear),
    .expired(iouv_exp)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  assign tx_fall = state_reg.tx_s && !state_reg.tx_sync[1];
  assign tx_rise = !state_reg.tx_s && state_reg.tx_sync[1];
  assign rx_rise = !state_reg.rx_s && state_reg.rx_sync[1];

  always_comb begin
    logic mode_chg;
    logic enter_normal;
    logic enter_silent;
    logic other_entry;
    logic low_power;
    logic local_any;
    logic wake_evt;
    cff_mode_t new_mode;
    state_next = state_reg;
    mode_chg = 1'b0;
    enter_normal = 1'b0;
    enter_silent = 1'b0;
    other_entry = 1'b0;
    low_power = 1'b0;
    local_any = 1'b0;
    wake_evt = 1'b0;
    new_mode = state_reg.mode;
    state_next.tx_sync = {state_reg.tx_sync[0], tx_data};
    state_next.tx_s = state_reg.tx_sync[1];
    state_next.rx_sync = {state_reg.rx_sync[0], rx_data};
    state_next.rx_s = state_reg.rx_sync[1];
    state_next.sense_s1 = sense;
    state_next.sense_s = state_reg.sense_s1;
    state_next.mode_s1 = mode_req;
    state_next.mode_s = state_reg.mode_s1;

    if (!(state_reg.mode_s == CFF_MODE_GOTOSLEEP && state_reg.f.wake_request_flag)) begin
      new_mode = state_reg.mode_s;
    end
    state_next.mode = new_mode;
    state_next.prev_mode = state_reg.mode;
    mode_chg = new_mode != state_reg.mode;
    enter_normal = mode_chg && new_mode == CFF_MODE_NORMAL;
    enter_silent = mode_chg && new_mode == CFF_MODE_SILENT;
    other_entry = mode_chg && new_mode != CFF_MODE_SILENT;
    low_power = state_reg.mode == CFF_MODE_STANDBY || state_reg.mode == CFF_MODE_GOTOSLEEP
      || state_reg.mode == CFF_MODE_SLEEP;

    state_next.f.logic_supply_undervoltage_flag = state_reg.sense_s.logic_uv
      && (luv_exp || state_reg.f.logic_supply_undervoltage_flag);
    state_next.f.io_supply_undervoltage_flag = state_reg.sense_s.io_uv
      && (iouv_exp || state_reg.f.io_supply_undervoltage_flag);
    state_next.f.battery_undervoltage_flag = state_reg.sense_s.battery_uv;

    if (state_reg.f.battery_undervoltage_flag && !state_reg.sense_s.battery_uv) begin
      state_next.f.cold_start_flag = 1'b1;
      wake_evt = 1'b1;
    end else if (enter_normal) begin
      state_next.f.cold_start_flag = 1'b0;
    end

    if (low_power && (state_reg.sense_s.local_wake || state_reg.sense_s.remote_wake)) begin
      wake_evt = 1'b1;
    end
    if (enter_normal || luv_exp || iouv_exp) begin
      state_next.f.wake_request_flag = 1'b0;
    end
    if (wake_evt) begin
      state_next.f.wake_request_flag = 1'b1;
    end
    if (wake_evt && !state_reg.f.wake_source_valid) begin
      state_next.f.wake_source_valid = 1'b1;
      state_next.f.wake_source_flag = !state_reg.sense_s.remote_wake;
    end else if (mode_chg && state_reg.mode == CFF_MODE_NORMAL) begin
      state_next.f.wake_source_valid = 1'b0;
    end

    if (can_active && !state_reg.tx_s && state_reg.sense_s.bus_short) begin
      state_next.short_seen = 1'b1;
    end
    if (tx_rise) begin
      state_next.short_seen = 1'b0;
      if (state_reg.short_seen) begin
        state_next.clean_edges = '0;
        if (state_reg.short_edges != CFF_EDGE_W'(CFF_EDGE_CNT)) begin
          state_next.short_edges = state_reg.short_edges + 3'h1;
        end
      end else begin
        state_next.short_edges = '0;
        if (state_reg.clean_edges != CFF_EDGE_W'(CFF_EDGE_CNT)) begin
          state_next.clean_edges = state_reg.clean_edges + 3'h1;
        end
      end
    end
    if (mode_chg && state_reg.mode == CFF_MODE_NORMAL) begin
      state_next.f.bus_short_flag = 1'b0;
    end else if (state_reg.mode == CFF_MODE_NORMAL
                 && state_next.short_edges == CFF_EDGE_W'(CFF_EDGE_CNT)) begin
      state_next.f.bus_short_flag = 1'b1;
    end else if (state_reg.mode == CFF_MODE_NORMAL
                 && state_next.clean_edges == CFF_EDGE_W'(CFF_EDGE_CNT)) begin
      state_next.f.bus_short_flag = 1'b0;
    end

    local_any = state_reg.f.tx_dominant_timeout_flag || state_reg.f.tx_rx_short_flag
      || state_reg.f.bus_stuck_dominant_flag || state_reg.f.thermal_shutdown_flag;
    if (mode_chg && (new_mode == CFF_MODE_NORMAL || new_mode == CFF_MODE_SILENT)
        && !can_active) begin
      state_next.f.tx_clamped_flag = !state_reg.tx_s;
    end else if (state_reg.tx_s && !state_reg.rx_s && !local_any) begin
      state_next.f.tx_clamped_flag = 1'b0;
    end

    if (tx_rise || other_entry) begin
      state_next.f.tx_dominant_timeout_flag = 1'b0;
    end
    if (dto_exp) begin
      state_next.f.tx_dominant_timeout_flag = 1'b1;
    end
    if ((tx_rise && !state_reg.rx_s) || other_entry) begin
      state_next.f.tx_rx_short_flag = 1'b0;
    end
    if (txrx_exp) begin
      state_next.f.tx_rx_short_flag = 1'b1;
    end
    if (rx_rise || other_entry) begin
      state_next.f.bus_stuck_dominant_flag = 1'b0;
    end
    if (busdom_exp) begin
      state_next.f.bus_stuck_dominant_flag = 1'b1;
    end
    state_next.f.thermal_shutdown_flag = state_reg.sense_s.overtemp;

    state_next.drv_en = can_active && !state_next.f.tx_clamped_flag
      && !state_next.f.tx_dominant_timeout_flag && !state_next.f.tx_rx_short_flag
      && !state_next.f.thermal_shutdown_flag;

    if (state_next.f.thermal_shutdown_flag) begin
      state_next.fault_low = 1'b1;
    end else if (enter_normal) begin
      state_next.fault_low = state_reg.f.wake_source_valid && state_reg.f.wake_source_flag;
    end else if (state_reg.mode == CFF_MODE_NORMAL && state_next.f.bus_short_flag) begin
      state_next.fault_low = 1'b1;
    end else if (enter_silent) begin
      if (state_reg.mode == CFF_MODE_NORMAL) begin
        state_next.fault_low = local_any || state_reg.f.tx_clamped_flag;
      end else begin
        state_next.fault_low = state_reg.f.cold_start_flag;
      end
    end else if (mode_chg || (state_reg.mode == CFF_MODE_NORMAL
                 && !state_next.f.bus_short_flag && !state_reg.f.wake_source_valid)) begin
      state_next.fault_low = 1'b0;
    end
    state_next.fault_pin = !state_next.fault_low;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= '0;
      state_reg.tx_sync <= 2'h3;
      state_reg.tx_s <= 1'b1;
      state_reg.rx_sync <= 2'h3;
      state_reg.rx_s <= 1'b1;
      state_reg.mode <= CFF_MODE_STANDBY;
      state_reg.prev_mode <= CFF_MODE_STANDBY;
      state_reg.mode_s1 <= CFF_MODE_STANDBY;
      state_reg.mode_s <= CFF_MODE_STANDBY;
      state_reg.fault_pin <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fault_indicator_low = state_reg.fault_pin;
  assign driver_enable = state_reg.drv_en;
  assign mode_active = state_reg.mode;
  assign flags = state_reg.f;
endmodule : cff_fault_flags

// ### cff_fault_flags_properties.sv
`timescale 1ns/1ps
module cff_fault_flags_checker
  import cff_pkg::*;
#(
  parameter int DOM_TIMEOUT_CYC = CFF_DOM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Inputs
  input wire logic tx_data,
  input wire cff_mode_t mode_req,
  input wire logic rx_data,
  input wire cff_sense_t sense,
  // Outputs
  input wire logic fault_indicator_low,
  input wire logic driver_enable,
  input wire cff_mode_t mode_active,
  input wire cff_flags_t flags
);
  int low_cnt;
  always_ff @(posedge clk_sys) begin
    if (tx_data) begin
      low_cnt <= 0;
    end else begin
      low_cnt <= low_cnt + 1;
    end
  end
  a_sleep_refused : assert property (@(posedge clk_sys) disable iff (!reset_n)
    flags.wake_request_flag && mode_active != CFF_MODE_GOTOSLEEP |=>
    mode_active != CFF_MODE_GOTOSLEEP) else $error("sleep entered with wake request");
  a_normal_clears : assert property (@(posedge clk_sys) disable iff (!reset_n)
    mode_active == CFF_MODE_NORMAL && $past(mode_active) != CFF_MODE_NORMAL |=>
    !flags.wake_request_flag && !flags.cold_start_flag) else $error("flags kept in normal");
  a_source_kept : assert property (@(posedge clk_sys) disable iff (!reset_n)
    flags.wake_source_valid && $past(flags.wake_source_valid) |->
    $stable(flags.wake_source_flag)) else $error("wake source overwritten");
  a_uv_filtered : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(flags.logic_supply_undervoltage_flag) |-> $past(sense.logic_uv, 10))
    else $error("undervoltage flag too early");
  a_timeout_late : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(flags.tx_dominant_timeout_flag) |-> low_cnt >= DOM_TIMEOUT_CYC)
    else $error("timeout flag too early");
  a_timeout_off : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(flags.tx_dominant_timeout_flag) |-> ##1 !driver_enable)
    else $error("driver on after timeout");
  a_clamp_off : assert property (@(posedge clk_sys) disable iff (!reset_n)
    flags.tx_clamped_flag [*2] |-> !driver_enable) else $error("driver on while clamped");
  a_thermal_off : assert property (@(posedge clk_sys) disable iff (!reset_n)
    flags.thermal_shutdown_flag [*2] |-> !driver_enable && !fault_indicator_low)
    else $error("thermal fault not handled");
  a_short_shown : assert property (@(posedge clk_sys) disable iff (!reset_n)
    (flags.bus_short_flag && mode_active == CFF_MODE_NORMAL) [*2] |-> !fault_indicator_low)
    else $error("bus short not shown");
  a_short_normal : assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(flags.bus_short_flag) |-> mode_active == CFF_MODE_NORMAL)
    else $error("bus short set outside normal");
endmodule : cff_fault_flags_checker

bind cff_fault_flags cff_fault_flags_checker #(.DOM_TIMEOUT_CYC(DOM_TIMEOUT_CYC)) u_checker (
  .clk_sys(clk_sys), .reset_n(reset_n), .tx_data(tx_data), .mode_req(mode_req),
  .rx_data(rx_data), .sense(sense), .fault_indicator_low(fault_indicator_low),
  .driver_enable(driver_enable), .mode_active(mode_active), .flags(flags));

// ### cff_controller_model.sv
`timescale 1ns/1ps
module cff_controller_model
  import cff_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Pins toward the transceiver
  output logic tx_data,
  output cff_mode_t mode_req
);
  initial begin
    tx_data = 1'b1;
    mode_req = CFF_MODE_STANDBY;
  end
  task set_mode(input cff_mode_t m);
    @(negedge clk_sys);
    mode_req = m;
    repeat (4) @(negedge clk_sys);
  endtask : set_mode
  task set_tx(input logic v);
    @(negedge clk_sys);
    tx_data = v;
  endtask : set_tx
  task send_bits(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      tx_data = 1'b0;
      repeat ($urandom_range(6, 2)) @(negedge clk_sys);
      tx_data = 1'b1;
      repeat ($urandom_range(4, 2)) @(negedge clk_sys);
    end
  endtask : send_bits
endmodule : cff_controller_model

// ### cff_fault_flags_test.sv
`timescale 1ns/1ps
`define CHECK(w, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; $display("mismatch %s expected %0h seen %0h", w, e, g); end end
module cff_fault_flags_test;
  import cff_pkg::*;
  localparam int DOM = 20;
  localparam int UVF = 10;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic rx_data = 1'b1;
  logic mirror = 1'b1;
  logic stuck = 1'b0;
  cff_sense_t sense = '0;
  logic tx_data;
  cff_mode_t mode_req;
  logic fault_indicator_low;
  logic driver_enable;
  cff_mode_t mode_active;
  cff_flags_t flags;
  int errors = 0;
  int samples_checked = 0;
  int edges_q[$];
  logic exp_short = 1'b0;
  always #2.5 clk_sys = ~clk_sys;
  // Receive path follows the bus, recessive once the driver lets go.
  always @(negedge clk_sys) rx_data <= stuck ? 1'b0 : mirror ? (tx_data | ~driver_enable) : 1'b1;
  always @(posedge tx_data) begin
    if (reset_n && mode_req == CFF_MODE_NORMAL) begin
      edges_q.push_back(int'(sense.bus_short));
      if (edges_q.size() > 4) void'(edges_q.pop_front());
      if (edges_q.size() == 4 && edges_q.sum() == 4) exp_short = 1'b1;
      if (edges_q.size() == 4 && edges_q.sum() == 0) exp_short = 1'b0;
    end
  end
  cff_fault_flags #(.DOM_TIMEOUT_CYC(DOM), .BUS_DOM_CYC(30), .UV_FILTER_CYC(UVF)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .tx_data(tx_data), .mode_req(mode_req),
    .rx_data(rx_data), .sense(sense), .fault_indicator_low(fault_indicator_low),
    .driver_enable(driver_enable), .mode_active(mode_active), .flags(flags));
  cff_controller_model ctl (.clk_sys(clk_sys), .tx_data(tx_data), .mode_req(mode_req));
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  task settle(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : settle
  task await_flag(input logic [12:0] mask, input logic val, input int bound);
    int i;
    for (i = 0; i < bound && ((|(flags & mask)) !== val); i++) @(negedge clk_sys);
    if (i == bound) begin
      errors++;
      $display("mismatch flag wait expected %0h seen %0h", val, |(flags & mask));
      conclude();
    end
  endtask : await_flag
  initial begin
    void'($urandom(56081));
    settle(6);
    `CHECK("reset flags", 13'h0000, flags)
    `CHECK("reset indicator", 1'b1, fault_indicator_low)
    `CHECK("reset driver", 1'b0, driver_enable)
    `CHECK("reset mode", CFF_MODE_STANDBY, mode_active)
    reset_n = 1'b1;
    sense.battery_uv = 1'b1;
    settle(5);
    `CHECK("indicator", 1'b1, fault_indicator_low)
    sense.battery_uv = 1'b0;
    await_flag(13'h1000, 1'b1, 20);
    `CHECK("wake request", 1'b1, flags.wake_request_flag)
    ctl.set_mode(CFF_MODE_GOTOSLEEP);
    `CHECK("sleep refused", 1'b0, mode_active == CFF_MODE_GOTOSLEEP)
    ctl.set_mode(CFF_MODE_SILENT);
    `CHECK("cold start shown", 1'b0, fault_indicator_low)
    ctl.set_mode(CFF_MODE_NORMAL);
    `CHECK("cold start", 1'b0, flags.cold_start_flag)
    `CHECK("wake request", 1'b0, flags.wake_request_flag)
    $display("test cold_start done");
    ctl.set_mode(CFF_MODE_STANDBY);
    ctl.set_mode(CFF_MODE_NORMAL);
    sense.bus_short = 1'b1;
    ctl.send_bits(4);
    settle(5);
    `CHECK("bus short", exp_short, flags.bus_short_flag)
    `CHECK("short shown", 1'b0, fault_indicator_low)
    `CHECK("driver kept", 1'b1, driver_enable)
    sense.bus_short = 1'b0;
    ctl.send_bits(3);
    settle(5);
    `CHECK("bus short held", exp_short, flags.bus_short_flag)
    ctl.send_bits(1);
    settle(5);
    `CHECK("bus short", exp_short, flags.bus_short_flag)
    `CHECK("indicator", 1'b1, fault_indicator_low)
    $display("test bus_short done");
    mirror = 1'b0;
    ctl.set_tx(1'b0);
    await_flag(13'h0040, 1'b1, DOM + 20);
    settle(2);
    `CHECK("driver off", 1'b0, driver_enable)
    ctl.set_tx(1'b1);
    await_flag(13'h0040, 1'b0, 10);
    settle(2);
    `CHECK("driver on", 1'b1, driver_enable)
    mirror = 1'b1;
    $display("test timeout done");
    ctl.set_mode(CFF_MODE_STANDBY);
    ctl.set_tx(1'b0);
    ctl.set_mode(CFF_MODE_NORMAL);
    `CHECK("clamped", 1'b1, flags.tx_clamped_flag)
    `CHECK("driver off", 1'b0, driver_enable)
    ctl.set_mode(CFF_MODE_SILENT);
    `CHECK("local fault shown", 1'b0, fault_indicator_low)
    ctl.set_tx(1'b1);
    ctl.set_mode(CFF_MODE_STANDBY);
    ctl.set_mode(CFF_MODE_NORMAL);
    `CHECK("clamped", 1'b0, flags.tx_clamped_flag)
    `CHECK("driver on", 1'b1, driver_enable)
    $display("test clamp done");
    sense.overtemp = 1'b1;
    settle(5);
    `CHECK("thermal", 1'b1, flags.thermal_shutdown_flag)
    `CHECK("driver off", 1'b0, driver_enable)
    `CHECK("thermal shown", 1'b0, fault_indicator_low)
    sense.overtemp = 1'b0;
    settle(5);
    `CHECK("thermal", 1'b0, flags.thermal_shutdown_flag)
    $display("test thermal done");
    stuck = 1'b1;
    await_flag(13'h0010, 1'b1, 60);
    `CHECK("driver kept", 1'b1, driver_enable)
    ctl.set_mode(CFF_MODE_SILENT);
    `CHECK("local fault shown", 1'b0, fault_indicator_low)
    stuck = 1'b0;
    await_flag(13'h0010, 1'b0, 10);
    `CHECK("bus dominant", 1'b0, flags.bus_stuck_dominant_flag)
    $display("test bus_dominant done");
    ctl.set_mode(CFF_MODE_STANDBY);
    sense.local_wake = 1'b1;
    settle(3);
    sense.local_wake = 1'b0;
    sense.remote_wake = 1'b1;
    settle(3);
    sense.remote_wake = 1'b0;
    settle(3);
    `CHECK("wake request", 1'b1, flags.wake_request_flag)
    `CHECK("wake source", 1'b1, flags.wake_source_flag)
    ctl.set_mode(CFF_MODE_NORMAL);
    `CHECK("source shown", 1'b0, fault_indicator_low)
    ctl.set_mode(CFF_MODE_STANDBY);
    sense.remote_wake = 1'b1;
    settle(3);
    sense.remote_wake = 1'b0;
    settle(3);
    `CHECK("wake request", 1'b1, flags.wake_request_flag)
    `CHECK("remote source", 1'b0, flags.wake_source_flag)
    sense.logic_uv = 1'b1;
    settle(UVF - 5);
    sense.logic_uv = 1'b0;
    settle(4);
    `CHECK("uv glitch", 1'b0, flags.logic_supply_undervoltage_flag)
    sense.logic_uv = 1'b1;
    settle(UVF + 8);
    `CHECK("uv flag", 1'b1, flags.logic_supply_undervoltage_flag)
    `CHECK("wake request", 1'b0, flags.wake_request_flag)
    sense.logic_uv = 1'b0;
    sense.io_uv = 1'b1;
    settle(4);
    sense.remote_wake = 1'b1;
    settle(3);
    sense.remote_wake = 1'b0;
    settle(9);
    `CHECK("uv restarted", 1'b0, flags.io_supply_undervoltage_flag)
    `CHECK("wake request", 1'b1, flags.wake_request_flag)
    settle(8);
    `CHECK("io uv flag", 1'b1, flags.io_supply_undervoltage_flag)
    `CHECK("wake request", 1'b0, flags.wake_request_flag)
    sense.io_uv = 1'b0;
    ctl.set_mode(CFF_MODE_GOTOSLEEP);
    `CHECK("sleep taken", CFF_MODE_GOTOSLEEP, mode_active)
    ctl.set_mode(CFF_MODE_SLEEP);
    sense.local_wake = 1'b1;
    settle(3);
    sense.local_wake = 1'b0;
    settle(3);
    `CHECK("sleep wake", 1'b1, flags.wake_request_flag)
    $display("test wake done");
    conclude();
  end
endmodule : cff_fault_flags_test
